// ---- src/swl_link_target.sv ----
// serial wire link target engine: bit protocol, debug port registers, access port requests
`timescale 1ns/1ps
module swl_link_target
  import swl_pkg::*;
#(
  parameter logic [31:0] SWL_ID_WORD = 32'h1000_0001  // arbitrary identification value
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        swclk,
  input  wire logic        swdio_i,
  output logic             swdio_o,
  output logic             swdio_oe,
  output logic             ap_req,
  output swl_ap_cmd_t      ap_cmd,
  input  wire logic        ap_done,
  input  wire logic [31:0] ap_rdata,
  input  wire logic        ap_err,
  output logic             swd_active,
  output logic             proto_lock
);

  logic        clk_s1, clk_s2, clk_s3;
  logic        dio_s1, dio_s2;
  logic        rise;
  logic        bit_in;
  swl_state_t  state, next_state;
  logic [5:0]  cnt, next_cnt;
  logic [5:0]  hi_cnt, next_hi_cnt;
  logic [15:0] sw_sh, next_sw_sh;
  logic [6:0]  req_sh, next_req_sh;
  swl_req_t    req, next_req;
  logic [2:0]  ack, next_ack;
  logic [32:0] dsh, next_dsh;
  logic        stk_err, next_stk_err;
  logic        wd_err, next_wd_err;
  logic [1:0]  pwr_req, next_pwr_req;
  logic [3:0]  bank, next_bank;
  logic [31:0] rdbuf, next_rdbuf;
  logic [31:0] last_rd, next_last_rd;
  logic        ap_pend, next_ap_pend;
  logic        next_swdio_o, next_swdio_oe, next_ap_req;
  swl_ap_cmd_t next_ap_cmd;
  logic        next_swd_active, next_proto_lock;
  swl_req_t    r;
  logic        bad;
  logic [31:0] word;
  logic [32:0] wsh;

  function automatic logic [31:0] ctrl_word(input logic [1:0] pw, input logic se,
                                            input logic we);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[SWL_PWR_DBG]     = pw[0];
    v[SWL_PWR_DBG + 1] = pw[0];
    v[SWL_PWR_SYS]     = pw[1];
    v[SWL_PWR_SYS + 1] = pw[1];
    v[SWL_STK_ERR]     = se;
    v[SWL_WD_ERR]      = we;
    return v;
  endfunction

  // the link clock is only ever sampled here, never driven
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clk_s1 <= 1'b0;
      clk_s2 <= 1'b0;
      clk_s3 <= 1'b0;
      dio_s1 <= 1'b0;
      dio_s2 <= 1'b0;
    end else begin
      clk_s1 <= swclk;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      dio_s1 <= swdio_i;
      dio_s2 <= dio_s1;
    end
  end

  // both paths carry equal delay, so data still pairs with its own edge
  assign rise   = clk_s2 & ~clk_s3;
  assign bit_in = dio_s2;

  always_comb begin
    next_state   = state;
    next_cnt     = cnt;
    next_hi_cnt  = hi_cnt;
    next_sw_sh   = sw_sh;
    next_req_sh  = req_sh;
    next_req     = req;
    next_ack     = ack;
    next_dsh     = dsh;
    next_stk_err = stk_err;
    next_wd_err  = wd_err;
    next_pwr_req = pwr_req;
    next_bank    = bank;
    next_rdbuf   = rdbuf;
    next_last_rd = last_rd;
    next_ap_pend = ap_pend;
    next_swdio_o = swdio_o;
    next_swdio_oe = swdio_oe;
    next_ap_req  = 1'b0;
    next_ap_cmd  = ap_cmd;
    r            = swl_req_t'({bit_in, req_sh[6:1]});
    bad          = 1'b0;
    word         = 32'h0000_0000;
    wsh          = {bit_in, dsh[32:1]};
    if (rise) begin
      // only the host's own high bits count toward a line reset
      if (!swdio_oe) begin
        if (!bit_in) begin
          next_hi_cnt = 6'h00;
        end else if (hi_cnt != SWL_LRST_BITS) begin
          next_hi_cnt = hi_cnt + 6'h01;
        end
      end
      next_sw_sh = {bit_in, sw_sh[15:1]};
      case (state)
        ST_JTAG: begin
          if (next_sw_sh == SWL_SWITCH_SEQ) begin
            next_state = ST_LOCK;  // a line reset must still follow
          end
        end
        ST_LOCK: begin
          next_swdio_oe = 1'b0;
        end
        ST_LRST: begin
          if (!bit_in) begin
            next_state = ST_IDLE;
          end
        end
        ST_IDLE: begin
          // low idle bits are skipped; a one is the start bit
          if (bit_in) begin
            next_state = ST_REQ;
            next_cnt   = 6'h00;
          end
        end
        ST_REQ: begin
          next_req_sh = {bit_in, req_sh[6:1]};
          next_cnt    = cnt + 6'h01;
          if (cnt == SWL_REQ_LAST) begin
            bad = (^{r.par, r.addr, r.rd, r.ap}) | r.stop | ~r.park;
            next_req = r;
            if (bad) begin
              next_state = ST_LOCK;
            end else begin
              next_state = ST_TRN1;
              if (stk_err || wd_err) begin
                // only identification, status read and abort stay open
                if (!r.ap && (r.rd ? !r.addr[1] : r.addr == SWL_DP_IDENT)) begin
                  next_ack = SWL_ACK_OK;
                end else begin
                  next_ack = SWL_ACK_FAULT;
                end
              end else if (r.ap && ap_pend) begin
                next_ack = SWL_ACK_WAIT;
              end else begin
                next_ack = SWL_ACK_OK;
              end
              if (r.ap) begin
                word = rdbuf;  // reads return the previous access result
              end else if (r.addr == SWL_DP_IDENT) begin
                word = SWL_ID_WORD;
              end else if (r.addr == SWL_DP_CTRL) begin
                word = ctrl_word(pwr_req, stk_err, wd_err);
              end else if (r.addr == SWL_DP_SELECT) begin
                word = last_rd;
              end else begin
                word = rdbuf;
              end
              next_dsh = {^word, word};
              if (r.rd && next_ack == SWL_ACK_OK) begin
                next_last_rd = word;
                if (r.ap) begin
                  next_ap_req  = 1'b1;
                  next_ap_pend = 1'b1;
                  next_ap_cmd  = '{write: 1'b0, addr: {bank, r.addr}, wdata: 32'h0000_0000};
                end
              end
            end
          end
        end
        ST_TRN1: begin
          next_swdio_oe = 1'b1;  // the turnaround bit itself is ignored
          next_swdio_o  = ack[0];
          next_cnt      = 6'h00;
          next_state    = ST_ACK;
        end
        ST_ACK: begin
          next_cnt = cnt + 6'h01;
          if (cnt != 6'h02) begin
            next_swdio_o = ack[cnt[1:0] + 2'h1];
          end else if (ack == SWL_ACK_OK && req.rd) begin
            next_swdio_o = dsh[0];
            next_cnt     = 6'h00;
            next_state   = ST_RDATA;
          end else begin
            next_swdio_oe = 1'b0;
            next_state    = (ack == SWL_ACK_OK) ? ST_TRN2 : ST_TRN3;
          end
        end
        ST_RDATA: begin
          next_cnt = cnt + 6'h01;
          next_dsh = {1'b0, dsh[32:1]};
          if (cnt == SWL_DATA_LAST) begin
            next_swdio_oe = 1'b0;
            next_state    = ST_TRN3;
          end else begin
            next_swdio_o = dsh[1];
          end
        end
        ST_TRN2: begin
          next_cnt   = 6'h00;
          next_state = ST_WDATA;
        end
        ST_WDATA: begin
          next_dsh = wsh;
          next_cnt = cnt + 6'h01;
          if (cnt == SWL_DATA_LAST) begin
            next_state = ST_IDLE;
            if (^wsh) begin
              next_wd_err = 1'b1;  // write dropped on bad parity
            end else if (req.ap) begin
              next_ap_req  = 1'b1;
              next_ap_pend = 1'b1;
              next_ap_cmd  = '{write: 1'b1, addr: {bank, req.addr}, wdata: wsh[31:0]};
            end else if (req.addr == SWL_DP_IDENT) begin
              if (wsh[SWL_CLR_STK]) begin
                next_stk_err = 1'b0;
              end
              if (wsh[SWL_CLR_WD]) begin
                next_wd_err = 1'b0;
              end
            end else if (req.addr == SWL_DP_CTRL) begin
              next_pwr_req = {wsh[SWL_PWR_SYS], wsh[SWL_PWR_DBG]};
            end else if (req.addr == SWL_DP_SELECT) begin
              next_bank = wsh[SWL_BANK_LO +: 4];
            end
          end
        end
        ST_TRN3: begin
          next_state = ST_IDLE;
        end
        default: begin
          next_state = ST_LOCK;
        end
      endcase
      // line reset overrides any serial wire state while the target is not driving the line
      if (state != ST_JTAG && !swdio_oe && bit_in && hi_cnt == SWL_LRST_BITS - 6'h01) begin
        next_state    = ST_LRST;
        next_swdio_oe = 1'b0;
      end
    end
    // completion is applied last so its error wins over an abort clear
    if (ap_done) begin
      next_rdbuf   = ap_rdata;
      next_ap_pend = 1'b0;
      if (ap_err) begin
        next_stk_err = 1'b1;
      end
    end
    next_swd_active = (next_state != ST_JTAG);
    next_proto_lock = (next_state == ST_LOCK);
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= ST_JTAG;
      cnt        <= 6'h00;
      hi_cnt     <= 6'h00;
      sw_sh      <= 16'h0000;
      req_sh     <= 7'h00;
      req        <= '0;
      ack        <= 3'h0;
      dsh        <= 33'h0_0000_0000;
      stk_err    <= 1'b0;
      wd_err     <= 1'b0;
      pwr_req    <= 2'h0;
      bank       <= 4'h0;
      rdbuf      <= 32'h0000_0000;
      last_rd    <= 32'h0000_0000;
      ap_pend    <= 1'b0;
      swdio_o    <= 1'b0;
      swdio_oe   <= 1'b0;
      ap_req     <= 1'b0;
      ap_cmd     <= '0;
      swd_active <= 1'b0;
      proto_lock <= 1'b0;
    end else begin
      state      <= next_state;
      cnt        <= next_cnt;
      hi_cnt     <= next_hi_cnt;
      sw_sh      <= next_sw_sh;
      req_sh     <= next_req_sh;
      req        <= next_req;
      ack        <= next_ack;
      dsh        <= next_dsh;
      stk_err    <= next_stk_err;
      wd_err     <= next_wd_err;
      pwr_req    <= next_pwr_req;
      bank       <= next_bank;
      rdbuf      <= next_rdbuf;
      last_rd    <= next_last_rd;
      ap_pend    <= next_ap_pend;
      swdio_o    <= next_swdio_o;
      swdio_oe   <= next_swdio_oe;
      ap_req     <= next_ap_req;
      ap_cmd     <= next_ap_cmd;
      swd_active <= next_swd_active;
      proto_lock <= next_proto_lock;
    end
  end

  AST_LOCK_SILENT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_LOCK && $past(state) == ST_LOCK |-> !swdio_oe)
    else $error("line driven while locked out");
  AST_BAD_REQ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_REQ && cnt == SWL_REQ_LAST && (r.stop || !r.park)
      && !(hi_cnt == SWL_LRST_BITS - 6'h01 && bit_in) |=> state == ST_LOCK ##1 !swdio_oe)
    else $error("bad request not treated as protocol error");
  AST_TRN_RELEASE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state inside {ST_TRN1, ST_TRN2, ST_WDATA} |-> !swdio_oe)
    else $error("target drives during turnaround or write data");
  AST_OK_FIRST: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_TRN1 && ack == SWL_ACK_OK |=> swdio_oe && swdio_o && state == ST_ACK)
    else $error("OK acknowledge does not start with one");
  AST_READ_DRIVE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    state == ST_RDATA |-> swdio_oe && ack == SWL_ACK_OK && req.rd)
    else $error("read data phase without drive or OK");
  AST_READ_PAR: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_RDATA && cnt == 6'h1F && swdio_oe |=> swdio_o == dsh[0])
    else $error("read parity bit out of place");
  AST_SWITCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_JTAG && {bit_in, sw_sh[15:1]} == SWL_SWITCH_SEQ
      |=> swd_active ##1 (state != ST_JTAG))
    else $error("switch pattern not honoured");
  AST_LINE_RST: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state != ST_JTAG && !swdio_oe && bit_in && hi_cnt == 6'h31 |=> state == ST_LRST)
    else $error("line reset not recognised");
  AST_FAULT_AP: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_REQ && cnt == SWL_REQ_LAST && !bad && r.ap && (stk_err || wd_err)
      && !(hi_cnt == SWL_LRST_BITS - 6'h01 && bit_in) |=> ack == SWL_ACK_FAULT)
    else $error("access port request not faulted while sticky");
  AST_ABORT: assert property (@(posedge sys_clk) disable iff (sys_rst)
    rise && state == ST_WDATA && cnt == SWL_DATA_LAST && !(^wsh) && !req.ap
      && req.addr == SWL_DP_IDENT && wsh[SWL_CLR_STK] && !ap_done |=> !stk_err)
    else $error("abort write did not clear sticky error");
endmodule

// ---- src/swl_pkg.sv ----
// constants, states and carriers for the serial wire link target engine
// Summary of operation
// - line high is one, low is zero
// - host drives write data, target read data
// - every field travels least significant bit first
// - target samples and launches on rising clock
// - request: start, port, read, A2, A3
// - request parity covers bits one to four
// - OK acknowledge is one then two zeros
// - data phase only after OK acknowledge
// - 32-bit word plus odd-ones parity bit
// - one ignored turnaround cycle per direction change
// - turnaround after request; write before data, read after
// - fifty or more high cycles return to reset
// - switch pattern 0xE79E enters serial wire mode
// - identification read answers OK, word, parity
// - sticky error keeps answering FAULT until cleared
// - protocol error: release line, answer nothing
// - A2, A3 and direction pick the register
// - abort register write clears sticky flags
package swl_pkg;
  localparam logic [15:0] SWL_SWITCH_SEQ = 16'hE79E;
  localparam logic [5:0]  SWL_LRST_BITS  = 6'h32;
  localparam logic [5:0]  SWL_REQ_LAST   = 6'h06;
  localparam logic [5:0]  SWL_DATA_LAST  = 6'h20;
  localparam logic [2:0]  SWL_ACK_OK     = 3'h1;
  localparam logic [2:0]  SWL_ACK_WAIT   = 3'h2;
  localparam logic [2:0]  SWL_ACK_FAULT  = 3'h4;
  localparam logic [1:0]  SWL_DP_IDENT   = 2'h0;
  localparam logic [1:0]  SWL_DP_CTRL    = 2'h1;
  localparam logic [1:0]  SWL_DP_SELECT  = 2'h2;
  localparam logic [1:0]  SWL_DP_RDBUF   = 2'h3;
  localparam int          SWL_STK_ERR    = 5;
  localparam int          SWL_WD_ERR     = 7;
  localparam int          SWL_PWR_DBG    = 28;
  localparam int          SWL_PWR_SYS    = 30;
  localparam int          SWL_CLR_STK    = 2;
  localparam int          SWL_CLR_WD     = 3;
  localparam int          SWL_BANK_LO    = 4;

  typedef enum logic [3:0] {
    ST_JTAG  = 4'h0,
    ST_LOCK  = 4'h1,
    ST_LRST  = 4'h2,
    ST_IDLE  = 4'h3,
    ST_REQ   = 4'h4,
    ST_TRN1  = 4'h5,
    ST_ACK   = 4'h6,
    ST_TRN2  = 4'h7,
    ST_WDATA = 4'h8,
    ST_RDATA = 4'h9,
    ST_TRN3  = 4'hA
  } swl_state_t;

  // request bits one to seven as they arrive after the start bit
  typedef struct packed {
    logic       park;
    logic       stop;
    logic       par;
    logic [1:0] addr;
    logic       rd;
    logic       ap;
  } swl_req_t;

  typedef struct packed {
    logic        write;
    logic [5:0]  addr;
    logic [31:0] wdata;
  } swl_ap_cmd_t;
endpackage

// ---- tb/swl_host_model.sv ----
// host probe model: drives the link clock and the host side of the data line
`timescale 1ns/1ps
module swl_host_model
  import swl_pkg::*;
(
  input  wire logic swdio_o,
  input  wire logic swdio_oe,
  output logic      swclk,
  output logic      line,
  output logic      oe_seen
);
  logic h_oe;
  logic h_o;

  // weak pull-up when nobody drives; both driving shows as unknown
  assign line = (swdio_oe && h_oe) ? 1'bx : swdio_oe ? swdio_o : h_oe ? h_o : 1'b1;

  initial begin
    swclk   = 1'b0;
    h_oe    = 1'b1;
    h_o     = 1'b0;
    oe_seen = 1'b0;
  end

  always @(posedge swdio_oe) oe_seen = 1'b1;

  // one link cycle: change on the low phase, sample just before the rise
  task automatic cyc(input logic drv, input logic b, output logic s);
    h_oe  = drv;
    h_o   = b;
    #24;
    s     = line;
    swclk = 1'b1;
    #24;
    swclk = 1'b0;
  endtask

  task automatic bits(input logic [63:0] v, input int n);
    logic s;
    for (int i = 0; i < n; i++) cyc(1'b1, v[i], s);
  endtask

  task automatic idle(input int n);
    bits(64'h0, n);
  endtask

  task automatic lrst(input int n);
    bits({64{1'b1}}, n);
  endtask

  task automatic init();
    lrst(52);
    bits(64'(SWL_SWITCH_SEQ), 16);
    lrst(52);
    idle(2);
  endtask

  // bad: 0 request parity, 1 stop set, 2 park clear, 3 data parity
  task automatic xfer(input logic ap, input logic rd, input logic [1:0] a,
                      input logic [31:0] wd, input logic [3:0] bad,
                      output logic [2:0] ack, output logic [31:0] rdat, output logic rp);
    logic [7:0] rq;
    logic       s;
    rq = {~bad[2], bad[1], ^{a, rd, ap} ^ bad[0], a, rd, ap, 1'b1};
    rdat = 32'h0;
    rp = 1'b0;
    oe_seen = 1'b0;
    bits(64'(rq), 8);
    cyc(1'b0, 1'b0, s);
    for (int i = 0; i < 3; i++) begin
      cyc(1'b0, 1'b0, s);
      ack[i] = s;
    end
    if (ack == SWL_ACK_OK && rd) begin
      for (int i = 0; i < 32; i++) begin
        cyc(1'b0, 1'b0, s);
        rdat[i] = s;
      end
      cyc(1'b0, 1'b0, rp);
      cyc(1'b0, 1'b0, s);
    end else if (ack == SWL_ACK_OK) begin
      cyc(1'b0, 1'b0, s);
      bits(64'(wd), 32);
      cyc(1'b1, ^wd ^ bad[3], s);
    end else begin
      cyc(1'b0, 1'b0, s);
    end
    idle(8);
  endtask
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the serial wire link target engine
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench
  import swl_pkg::*;
;
  localparam logic [31:0] ID_WORD = 32'h5A3C_0F01; // arbitrary identification value
  logic        sys_clk;
  logic        sys_rst;
  logic        ap_done;
  logic        ap_err;
  logic [31:0] ap_rdata;
  wire logic   swclk;
  wire logic   line;
  wire logic   oe_seen;
  logic        swdio_o;
  logic        swdio_oe;
  logic        ap_req;
  logic        swd_active;
  logic        proto_lock;
  swl_ap_cmd_t ap_cmd;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          ap_lat = 3;
  int          ap_cnt = -1;
  int          ap_reqs = 0;
  logic [31:0] ap_val = 32'h0;
  logic        ap_fail = 1'b0;
  logic [2:0]  ack;
  logic [31:0] rdat;
  logic        rp;

  swl_link_target #(.SWL_ID_WORD(ID_WORD)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .swclk(swclk), .swdio_i(line),
    .swdio_o(swdio_o), .swdio_oe(swdio_oe), .ap_req(ap_req), .ap_cmd(ap_cmd),
    .ap_done(ap_done), .ap_rdata(ap_rdata), .ap_err(ap_err),
    .swd_active(swd_active), .proto_lock(proto_lock));

  swl_host_model u_host (.swdio_o(swdio_o), .swdio_oe(swdio_oe), .swclk(swclk),
    .line(line), .oe_seen(oe_seen));

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // access port responder with adjustable latency; data scrambled when not valid
  always @(negedge sys_clk) begin
    ap_done <= 1'b0;
    ap_err <= 1'b0;
    ap_rdata <= ~ap_rdata;
    if (sys_rst) begin
      ap_rdata <= 32'h0;
      ap_cnt <= -1;
    end else if (ap_req) begin
      ap_reqs <= ap_reqs + 1;
      ap_cnt <= ap_lat;
    end else if (ap_cnt == 0) begin
      ap_done <= 1'b1;
      ap_rdata <= ap_val;
      ap_err <= ap_fail;
      ap_cnt <= -1;
    end else if (ap_cnt > 0) begin
      ap_cnt <= ap_cnt - 1;
    end
  end

  task automatic acc(input logic ap, input logic rd, input logic [1:0] a,
                     input logic [31:0] wd, input logic [3:0] bad, input logic [2:0] eack);
    u_host.xfer(ap, rd, a, wd, bad, ack, rdat, rp);
    `CHK(ack, eack)
    if (rd && eack == SWL_ACK_OK) `CHK(rp, ^rdat)
  endtask

  task automatic t_jtag();
    acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, 3'h7);
    `CHK(oe_seen, 1'b0)
    `CHK(swd_active, 1'b0)
    u_host.lrst(52);
    u_host.bits(64'(SWL_SWITCH_SEQ), 16);
    `CHK(swd_active, 1'b1)
    u_host.idle(2);
    u_host.lrst(49);
    u_host.idle(2);
    `CHK(proto_lock, 1'b1)
    acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, 3'h7);
    u_host.lrst(50);
    u_host.idle(2);
    `CHK(proto_lock, 1'b0)
    acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, ID_WORD)
    $display("done: mode switch");
  endtask

  task automatic t_dp();
    acc(1'b0, 1'b0, 2'h2, 32'h0000_00F0, 4'h0, SWL_ACK_OK);
    acc(1'b0, 1'b0, 2'h1, 32'h5000_0000, 4'h0, SWL_ACK_OK);
    acc(1'b0, 1'b0, 2'h3, 32'hFFFF_FFFF, 4'h0, SWL_ACK_OK);
    acc(1'b0, 1'b1, 2'h1, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hF000_0000)
    acc(1'b0, 1'b1, 2'h2, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hF000_0000)
    $display("done: debug port registers");
  endtask

  task automatic t_ap();
    int n;
    n = ap_reqs;
    ap_val = 32'hC3A5_1E0F;
    acc(1'b1, 1'b0, 2'h1, 32'h2000_1000, 4'h0, SWL_ACK_OK);
    `CHK(ap_cmd, swl_ap_cmd_t'{1'b1, 6'h3D, 32'h2000_1000})
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(ap_cmd.addr, 6'h3F)
    `CHK(ap_cmd.write, 1'b0)
    `CHK(ap_reqs - n, 2)
    acc(1'b0, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hC3A5_1E0F)
    ap_val = 32'h0F0F_7777;
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hC3A5_1E0F)
    ap_lat = 1500;
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_OK);
    n = ap_reqs;
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_WAIT);
    u_host.idle(200);
    `CHK(ap_reqs - n, 0)
    // short latency again so this retry leaves nothing pending for later tests
    ap_lat = 3;
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'h0F0F_7777)
    $display("done: access port");
  endtask

  task automatic t_fault();
    ap_fail = 1'b1;
    acc(1'b1, 1'b0, 2'h0, 32'h0000_0002, 4'h0, SWL_ACK_OK);
    ap_fail = 1'b0;
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_FAULT);
    acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, SWL_ACK_OK);
    acc(1'b0, 1'b1, 2'h1, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hF000_0020)
    acc(1'b0, 1'b0, 2'h0, 32'h0000_0004, 4'h0, SWL_ACK_OK);
    acc(1'b0, 1'b1, 2'h1, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hF000_0000)
    acc(1'b0, 1'b0, 2'h2, 32'h0, 4'h8, SWL_ACK_OK);
    acc(1'b1, 1'b1, 2'h3, 32'h0, 4'h0, SWL_ACK_FAULT);
    acc(1'b0, 1'b1, 2'h1, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, 32'hF000_0080)
    acc(1'b0, 1'b0, 2'h0, 32'h0000_0008, 4'h0, SWL_ACK_OK);
    acc(1'b1, 1'b1, 2'h1, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(ap_cmd.addr, 6'h3D)
    $display("done: sticky errors");
  endtask

  task automatic t_proto();
    for (int i = 0; i < 3; i++) begin
      acc(1'b0, 1'b1, 2'h0, 32'h0, 4'(1 << i), 3'h7);
      `CHK(oe_seen, 1'b0)
      `CHK(proto_lock, 1'b1)
      u_host.init();
      acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, SWL_ACK_OK);
      `CHK(rdat, ID_WORD)
    end
    $display("done: protocol errors");
  endtask

  // system reset in serial wire mode must fall back to the default mode
  task automatic t_reset();
    @(negedge sys_clk);
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    `CHK(swd_active, 1'b0)
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, 3'h7);
    `CHK(oe_seen, 1'b0)
    u_host.init();
    acc(1'b0, 1'b1, 2'h0, 32'h0, 4'h0, SWL_ACK_OK);
    `CHK(rdat, ID_WORD)
    $display("done: mid-run reset");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_jtag();
    t_dp();
    t_ap();
    t_fault();
    t_proto();
    t_reset();
    results();
  end

  // the full sequence needs well under 200 us of link traffic
  initial begin
    #400_000;
    num_errors++;
    $display("watchdog expired");
    results();
  end
endmodule
